/* hdl/asu_core.v */
// Asynchronous serial transceiver core with its CPU-side registers.
// Assumes strobes are one sys_clk wide and serial_in_pin is synchronous to sys_clk.
// How it works
// - Seven or eight data bits, both directions
// - Least significant bit first, always
// - Bit rate from 5-bit divider counter
// - Base clock chosen among four sources
// - Transmit and receive enabled independently
// - Enables synchronised to base clock ticks
// - Stopped clock freezes registers and pin
// - Completed character copied into holding buffer
// - Seven-bit characters read with top zero
// - Overrun keeps previous buffer contents
// - Holding buffer read-only, resets to ones
// - Writing transmit register starts a frame
// - Transmit register ones on reset/disable
// - Power off is the idle stop mode
// - Receive shifter deserialises the input pin
// - Power off resets unit, forces input high
// - One or two stop bits transmitted
// - Parity, framing, overrun flags; read clears
`include "asu_regs.vh"

module asu_core (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       mode_wr,
    input  wire [7:0] mode_wdata,
    output reg  [7:0] mode_rdata,
    input  wire       baud_wr,
    input  wire [7:0] baud_wdata,
    output reg  [7:0] baud_rdata,
    input  wire       txs_wr,
    input  wire [7:0] txs_wdata,
    input  wire       rxb_rd,
    output reg  [7:0] rxb_rdata,
    input  wire       err_rd,
    output reg  [7:0] err_rdata,
    input  wire       serial_in_pin,
    output reg        serial_out_pin,
    output reg        tx_done_irq,
    output reg        rx_done
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_STRT = 5'h02;
    localparam [4:0] ST_DATA = 5'h04;
    localparam [4:0] ST_PAR  = 5'h08;
    localparam [4:0] ST_STOP = 5'h10;

    // Odd-weight test over 7 or 8 bits
    function par_of;
        input [7:0] d;
        input       eight;
        begin
            par_of = ^d[6:0] ^ (eight & d[7]);
        end
    endfunction

    wire       power    = mode_rdata[`ASU_MODE_POWER];
    wire [1:0] par_mode = {mode_rdata[`ASU_MODE_PS_HI], mode_rdata[`ASU_MODE_PS_LO]};
    wire       eight    = mode_rdata[`ASU_MODE_CL];
    wire [2:0] last_bit = eight ? 3'h7 : 3'h6;
    wire       base_tick;
    wire       half_tick;

    asu_baud_gen u_baud (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .run       (power),
        .base_sel  (baud_rdata[`ASU_BAUD_SEL_HI:`ASU_BAUD_SEL_LO]),
        .div_val   (baud_rdata[`ASU_BAUD_DIV_HI:`ASU_BAUD_DIV_LO]),
        .base_tick (base_tick),
        .half_tick (half_tick)
    );

    // Enables pass two base ticks, so a clear that spans no base tick leaves the path running
    reg  [1:0] txe_sync_r;
    reg  [1:0] rxe_sync_r;
    wire       tx_en = txe_sync_r[1];
    wire       rx_en = rxe_sync_r[1];
    // Input forced high while powered off
    wire       rx_in = power ? serial_in_pin : 1'b1;

    reg  [7:0] txs_r;
    reg        tx_go_r;
    reg  [4:0] tx_st_r;
    reg  [7:0] tx_sh_r;
    reg  [2:0] tx_cnt_r;
    reg        tx_hc_r;
    reg        tx_par_r;

    reg  [4:0] rx_st_r;
    reg  [7:0] rx_sh_r;
    reg  [2:0] rx_cnt_r;
    reg        rx_hc_r;
    reg        rx_par_r;
    reg        rxb_full_r;

    // Register writes; reset loads reset values, power off clears only the enable synchronisers
    // A stopped sys_clk simply freezes all state and the pin level
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_rdata <= `ASU_MODE_RESET;
            baud_rdata <= `ASU_BAUD_RESET;
            txe_sync_r <= 2'h0;
            rxe_sync_r <= 2'h0;
        end else begin
            if (mode_wr)
                mode_rdata <= {mode_wdata[7:1], 1'b1};
            if (baud_wr)
                baud_rdata <= baud_wdata;
            if (!power) begin
                txe_sync_r <= 2'h0;
                rxe_sync_r <= 2'h0;
            end else if (base_tick) begin
                txe_sync_r <= {txe_sync_r[0], mode_rdata[`ASU_MODE_TXE]};
                rxe_sync_r <= {rxe_sync_r[0], mode_rdata[`ASU_MODE_RXE]};
            end
        end
    end

    // Transmitter
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            txs_r          <= `ASU_DATA_RESET;
            tx_go_r        <= 1'b0;
            tx_st_r        <= ST_IDLE;
            tx_sh_r        <= 8'hff;
            tx_cnt_r       <= 3'h0;
            tx_hc_r        <= 1'b0;
            tx_par_r       <= 1'b0;
            serial_out_pin <= 1'b1;
            tx_done_irq    <= 1'b0;
        end else if (!power || !tx_en) begin
            txs_r          <= `ASU_DATA_RESET;
            tx_go_r        <= 1'b0;
            tx_st_r        <= ST_IDLE;
            tx_hc_r        <= 1'b0;
            serial_out_pin <= 1'b1;
            tx_done_irq    <= 1'b0;
        end else begin
            tx_done_irq <= 1'b0;
            if (txs_wr) begin
                txs_r   <= txs_wdata;
                tx_go_r <= 1'b1;
            end
            if (half_tick)
                tx_hc_r <= ~tx_hc_r;
            case (tx_st_r)
                ST_IDLE: begin
                    serial_out_pin <= 1'b1;
                    tx_hc_r        <= 1'b0;
                    if (tx_go_r) begin
                        tx_go_r        <= 1'b0;
                        tx_sh_r        <= txs_r;
                        tx_par_r       <= par_of(txs_r, eight);
                        serial_out_pin <= 1'b0;
                        tx_st_r        <= ST_STRT;
                    end
                end
                ST_STRT: begin
                    if (half_tick && tx_hc_r) begin
                        serial_out_pin <= tx_sh_r[0];
                        tx_sh_r        <= {1'b1, tx_sh_r[7:1]};
                        tx_cnt_r       <= 3'h0;
                        tx_st_r        <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (half_tick && tx_hc_r) begin
                        if (tx_cnt_r == last_bit) begin
                            tx_cnt_r <= 3'h0;
                            case (par_mode)
                                `ASU_PAR_NONE: begin
                                    serial_out_pin <= 1'b1;
                                    tx_st_r        <= ST_STOP;
                                end
                                `ASU_PAR_ZERO: begin
                                    serial_out_pin <= 1'b0;
                                    tx_st_r        <= ST_PAR;
                                end
                                `ASU_PAR_ODD: begin
                                    serial_out_pin <= ~tx_par_r;
                                    tx_st_r        <= ST_PAR;
                                end
                                default: begin
                                    serial_out_pin <= tx_par_r;
                                    tx_st_r        <= ST_PAR;
                                end
                            endcase
                        end else begin
                            serial_out_pin <= tx_sh_r[0];
                            tx_sh_r        <= {1'b1, tx_sh_r[7:1]};
                            tx_cnt_r       <= tx_cnt_r + 3'h1;
                        end
                    end
                end
                ST_PAR: begin
                    if (half_tick && tx_hc_r) begin
                        serial_out_pin <= 1'b1;
                        tx_st_r        <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (half_tick && tx_hc_r) begin
                        if (mode_rdata[`ASU_MODE_SL] && tx_cnt_r == 3'h0) begin
                            tx_cnt_r <= 3'h1;
                        end else begin
                            tx_done_irq <= 1'b1;
                            tx_st_r     <= ST_IDLE;
                        end
                    end
                end
                default: tx_st_r <= ST_IDLE;
            endcase
        end
    end

    // Receiver; checks the start bit at the next half tick after the falling edge, then samples once per bit
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_r    <= ST_IDLE;
            rx_sh_r    <= 8'h00;
            rx_cnt_r   <= 3'h0;
            rx_hc_r    <= 1'b0;
            rx_par_r   <= 1'b0;
            rxb_full_r <= 1'b0;
            rxb_rdata  <= `ASU_DATA_RESET;
            err_rdata  <= `ASU_ERR_RESET;
            rx_done    <= 1'b0;
        end else if (!power) begin
            rx_st_r    <= ST_IDLE;
            rxb_full_r <= 1'b0;
            rxb_rdata  <= `ASU_DATA_RESET;
            err_rdata  <= `ASU_ERR_RESET;
            rx_done    <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            // Clears first; a same-cycle set below wins
            if (rxb_rd)
                rxb_full_r <= 1'b0;
            if (err_rd)
                err_rdata <= `ASU_ERR_RESET;
            if (half_tick)
                rx_hc_r <= ~rx_hc_r;
            if (!rx_en) begin
                rx_st_r <= ST_IDLE;
            end else begin
                case (rx_st_r)
                    ST_IDLE: begin
                        rx_hc_r <= 1'b0;
                        if (!rx_in) begin
                            rx_sh_r <= 8'h00;
                            rx_st_r <= ST_STRT;
                        end
                    end
                    ST_STRT: begin
                        if (half_tick) begin
                            rx_hc_r  <= 1'b0;
                            rx_cnt_r <= 3'h0;
                            // A glitch that has ended by the next half tick is dropped
                            rx_st_r  <= rx_in ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (half_tick && rx_hc_r) begin
                            rx_sh_r[rx_cnt_r] <= rx_in;
                            rx_cnt_r          <= rx_cnt_r + 3'h1;
                            if (rx_cnt_r == last_bit)
                                rx_st_r <= (par_mode == `ASU_PAR_NONE) ? ST_STOP : ST_PAR;
                        end
                    end
                    ST_PAR: begin
                        if (half_tick && rx_hc_r) begin
                            rx_par_r <= rx_in;
                            rx_st_r  <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        // Only the first stop bit is checked
                        if (half_tick && rx_hc_r) begin
                            rx_st_r <= ST_IDLE;
                            rx_done <= 1'b1;
                            if (!rx_in)
                                err_rdata[`ASU_ERR_FE] <= 1'b1;
                            if (par_mode[1] &&
                                (rx_par_r ^ par_of(rx_sh_r, eight) ^ ~par_mode[0]) == 1'b1)
                                err_rdata[`ASU_ERR_PE] <= 1'b1;
                            if (rxb_full_r && !rxb_rd) begin
                                err_rdata[`ASU_ERR_OVE] <= 1'b1;
                            end else begin
                                rxb_rdata  <= rx_sh_r;
                                rxb_full_r <= 1'b1;
                            end
                        end
                    end
                    default: rx_st_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* hdl/asu_regs.vh */
// Register layouts, reset values, parity modes and enable synchroniser depth for the serial core.
// Assumes it is included by the core and its baud generator only.
`ifndef ASU_REGS_VH
`define ASU_REGS_VH

// Mode control register fields
`define ASU_MODE_RESET      8'h01
`define ASU_MODE_POWER      7
`define ASU_MODE_TXE        6
`define ASU_MODE_RXE        5
`define ASU_MODE_PS_HI      4
`define ASU_MODE_PS_LO      3
`define ASU_MODE_CL         2
`define ASU_MODE_SL         1
`define ASU_MODE_FIXED      0

// Baud divider control fields
`define ASU_BAUD_RESET      8'h1f
`define ASU_BAUD_SEL_HI     7
`define ASU_BAUD_SEL_LO     6
`define ASU_BAUD_DIV_HI     4
`define ASU_BAUD_DIV_LO     0

// Error status fields
`define ASU_ERR_RESET       8'h00
`define ASU_ERR_PE          2
`define ASU_ERR_FE          1
`define ASU_ERR_OVE         0

// Data register reset value
`define ASU_DATA_RESET      8'hff

// Parity modes
`define ASU_PAR_NONE        2'h0
`define ASU_PAR_ZERO        2'h1
`define ASU_PAR_ODD         2'h2
`define ASU_PAR_EVEN        2'h3

// Enable synchroniser depth in base clock ticks
`define ASU_EN_SYNC_TICKS   2

`endif

/* hdl/asu_baud_gen.v */
// Baud generator: base clock select from four prescaled sources and a 5-bit divider.
// Assumes sys_clk is the peripheral clock; outputs single-cycle tick pulses.
`include "asu_regs.vh"

module asu_baud_gen (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       run,
    input  wire [1:0] base_sel,
    input  wire [4:0] div_val,
    output reg        base_tick,
    output reg        half_tick
);
    reg  [2:0] pre_r;
    reg  [4:0] div_r;
    reg        sel_hit;
    wire [4:0] div_lim = (div_val == 5'h00) ? 5'h01 : div_val;

    // Four base sources: sys_clk divided by 1, 2, 4 or 8
    always @* begin
        case (base_sel)
            2'h0:    sel_hit = 1'b1;
            2'h1:    sel_hit = (pre_r[0] == 1'b1);
            2'h2:    sel_hit = (pre_r[1:0] == 2'h3);
            default: sel_hit = (pre_r == 3'h7);
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r     <= 3'h0;
            div_r     <= 5'h00;
            base_tick <= 1'b0;
            half_tick <= 1'b0;
        end else if (!run) begin
            // Power off holds the internal clock low
            pre_r     <= 3'h0;
            div_r     <= 5'h00;
            base_tick <= 1'b0;
            half_tick <= 1'b0;
        end else begin
            pre_r     <= pre_r + 3'h1;
            base_tick <= sel_hit;
            half_tick <= 1'b0;
            if (sel_hit) begin
                // One half bit per div_lim base ticks
                if (div_r + 5'h01 >= div_lim) begin
                    div_r     <= 5'h00;
                    half_tick <= 1'b1;
                end else begin
                    div_r <= div_r + 5'h01;
                end
            end
        end
    end
endmodule

/* test/asu_core_chk.sv */
// Port-level assertions for the serial core.
// Assumes binding to asu_core, sharing its clock and reset.
module asu_core_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic [7:0] mode_rdata,
    input wire logic [7:0] baud_rdata,
    input wire logic [7:0] rxb_rdata,
    input wire logic [7:0] err_rdata,
    input wire logic       err_rd,
    input wire logic       serial_out_pin,
    input wire logic       tx_done_irq,
    input wire logic       rx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Power-off reset lands one edge after the mode write
    sequence s_off;
        !mode_rdata[7] ##1 !mode_rdata[7];
    endsequence
    // Only the fast selects settle a disable within eight cycles
    sequence s_tx_off;
        (!mode_rdata[6] && !baud_rdata[7]) [*8];
    endsequence
    sequence s_rx_end;
        rx_done || $past(rx_done);
    endsequence
    chk_off_pin: assert property (s_off |-> serial_out_pin)
        else $error("out pin low while powered off");
    chk_off_rxb: assert property (s_off |-> rxb_rdata == 8'hff)
        else $error("holding buffer not all ones while off");
    chk_off_err: assert property (s_off |-> err_rdata == 8'h00)
        else $error("error flags set while off");
    chk_tx_off: assert property (s_tx_off |-> serial_out_pin)
        else $error("out pin low with transmit disabled");
    chk_fall_en: assert property ($fell(serial_out_pin) |-> mode_rdata[7] && mode_rdata[6])
        else $error("frame started with transmit path off");
    chk_rxb_src: assert property (mode_rdata[7] && $past(mode_rdata[7]) && $changed(rxb_rdata)
        |-> s_rx_end)
        else $error("holding buffer changed without a frame");
    chk_seven_top: assert property ($changed(rxb_rdata) && mode_rdata[7] && !mode_rdata[2]
        |-> !rxb_rdata[7])
        else $error("seven-bit character with top bit set");
    chk_ovr_keep: assert property ($rose(err_rdata[0]) |-> $stable(rxb_rdata))
        else $error("overrun overwrote holding buffer");
    chk_flag_src: assert property ($rose(err_rdata[2]) || $rose(err_rdata[1]) |-> s_rx_end)
        else $error("error flag set outside frame end");
    chk_read_clr: assert property (err_rd |=> (err_rdata == 8'h00) or s_rx_end)
        else $error("status read did not clear flags");
    chk_done_idle: assert property (tx_done_irq |-> serial_out_pin ##1 !tx_done_irq)
        else $error("done pulse wrong or line not idle");
endmodule

bind asu_core asu_core_chk asu_core_chk_i (.sys_clk, .rst_n, .mode_rdata, .baud_rdata,
    .rxb_rdata, .err_rdata, .err_rd, .serial_out_pin, .tx_done_irq, .rx_done);

/* test/asu_remote.sv */
// Remote serial station: sends frames to the core and captures its output.
// Assumes bit_cyc sys_clk cycles per bit, set by the bench.
module asu_remote (
    input wire logic sys_clk,
    input int        bit_cyc,
    input wire logic line_in,
    output logic     line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] rx_q[$];
    logic [9:0] w;
    initial line_out = 1'b1;

    task automatic hold(input logic v);
        line_out = v;
        repeat (bit_cyc) @(negedge sys_clk);
    endtask

    // Start low, data LSB first, parity, one stop
    task automatic send(input logic [7:0] d, input logic c8, input logic [1:0] pm,
                        input logic bad_par, input logic bad_stop);
        logic p;
        p = ^(c8 ? d : {1'b0, d[6:0]});
        @(negedge sys_clk);
        hold(1'b0);
        for (int i = 0; i < (c8 ? 8 : 7); i++) hold(d[i]);
        if (pm != 2'h0) hold(bad_par ^ (pm == 2'h1 ? 1'b0 : (pm == 2'h2 ? ~p : p)));
        hold(~bad_stop);
        line_out = 1'b1;
    endtask

    // Quarter-bit sample point, as every start bit may run short
    always begin
        @(negedge line_in);
        repeat (bit_cyc + bit_cyc / 4) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            w[i] = line_in;
            repeat (bit_cyc) @(posedge sys_clk);
        end
        rx_q.push_back(w);
    end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the serial core, both lines and all registers.
// Assumes the core, its checker and the remote station model.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [4:0] stb = 5'h00;
    logic [7:0] mode_wdata = 8'h01;
    logic [7:0] baud_wdata = 8'h1f;
    logic [7:0] txs_wdata = 8'h00;
    logic [7:0] mode_rdata, baud_rdata, rxb_rdata, err_rdata, d, e;
    logic       serial_in_pin, serial_out_pin, tx_done_irq, rx_done, c8, sl, bp, bs;
    logic [1:0] pm;
    int         bit_cyc = 8;
    int         sel, div;
    int         bad_count = 0;
    int         checked = 0;

    always #20 sys_clk = ~sys_clk;

    asu_core asu_core_i (.sys_clk, .rst_n, .mode_wr(stb[0]), .mode_wdata, .mode_rdata,
        .baud_wr(stb[1]), .baud_wdata, .baud_rdata, .txs_wr(stb[2]), .txs_wdata,
        .rxb_rd(stb[3]), .rxb_rdata, .err_rd(stb[4]), .err_rdata, .serial_in_pin,
        .serial_out_pin, .tx_done_irq, .rx_done);
    asu_remote asu_remote_i (.sys_clk, .bit_cyc, .line_in(serial_out_pin),
        .line_out(serial_in_pin));

    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic poke(input int k, input logic [7:0] v);
        @(negedge sys_clk);
        if (k == 0) mode_wdata = v;
        if (k == 1) baud_wdata = v;
        if (k == 2) txs_wdata = v;
        stb[k] = 1'b1;
        @(negedge sys_clk);
        stb[k] = 1'b0;
    endtask

    // Pulses are one cycle wide, so look mid-cycle
    task automatic wait_for(input int k);
        int n;
        for (n = 0; n < 3000 && (k ? rx_done : tx_done_irq) !== 1'b1; n++) @(negedge sys_clk);
        check("pulse", n < 3000, 1'b1);
    endtask

    function automatic logic [9:0] exp_line(input logic [7:0] v, input logic e8,
                                            input logic [1:0] pmode);
        logic [9:0] w;
        logic       p;
        w = 10'h3ff;
        p = ^(e8 ? v : {1'b0, v[6:0]});
        for (int i = 0; i < 8; i++) if (i < 7 || e8) w[i] = v[i];
        if (pmode != 2'h0) w[e8 ? 8 : 7] = pmode == 2'h1 ? 1'b0 : (pmode == 2'h2 ? ~p : p);
        return w;
    endfunction

    task automatic summarize;
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end

    initial begin
        void'($urandom(9));
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        check("mode", mode_rdata, 8'h01);
        check("baud", baud_rdata, 8'h1f);
        check("rxb", rxb_rdata, 8'hff);
        check("err", err_rdata, 8'h00);
        for (int i = 0; i < 16; i++) begin
            sel = i % 4;
            pm = 2'(i / 4);
            div = sel == 0 ? 31 : (sel == 1 ? 2 : (sel == 2 ? 1 : 0));
            bit_cyc = 2 * (div == 0 ? 1 : div) << sel;
            {d, e, c8, sl} = 18'($urandom);
            if (i < 2) d = i ? 8'hff : 8'h00;
            bp = i % 3 == 1;
            bs = i % 5 == 2;
            poke(0, 8'h01);
            repeat (2) @(negedge sys_clk);
            check("rxb_off", rxb_rdata, 8'hff);
            poke(1, {sel[1:0], 1'b0, div[4:0]});
            poke(0, 8'h81);
            poke(2, d);
            repeat (40) @(negedge sys_clk);
            check("baud", baud_rdata, {sel[1:0], 1'b0, div[4:0]});
            check("refused", {serial_out_pin, asu_remote_i.rx_q.size() == 0}, 2'h3);
            poke(0, {3'h7, pm, c8, sl, 1'b1});
            repeat (40) @(negedge sys_clk);
            fork
                begin
                    poke(2, d);
                    wait_for(0);
                    for (int n = 0; n < 3000 && asu_remote_i.rx_q.size() == 0; n++)
                        @(negedge sys_clk);
                    check("tx_line", asu_remote_i.rx_q.pop_front(), exp_line(d, c8, pm));
                end
                begin
                    fork
                        asu_remote_i.send(e, c8, pm, bp, bs);
                        wait_for(1);
                    join
                    check("rxb", rxb_rdata, c8 ? e : {1'b0, e[6:0]});
                    check("err", err_rdata, {5'h00, bp & pm[1], bs, 1'b0});
                    poke(3, 8'h00);
                    poke(4, 8'h00);
                    check("err_clr", err_rdata, 8'h00);
                end
            join
        end
        poke(0, 8'h01);
        poke(1, 8'h42);
        poke(0, 8'h81);
        bit_cyc = 8;
        poke(0, 8'hbd);
        repeat (40) @(negedge sys_clk);
        for (int j = 0; j < 2; j++) begin
            fork
                asu_remote_i.send(8'h5a ^ 8'(j), 1'b1, 2'h3, 1'b0, 1'b0);
                wait_for(1);
            join
        end
        check("ovr_rxb", rxb_rdata, 8'h5a);
        check("ovr_err", err_rdata, 8'h01);
        summarize();
    end
endmodule
